// >>> include/pcwl_pkg.sv
// Package: constants and carriers of the port configuration word loader
`default_nettype none
package pcwl_pkg;
    // Register bus: {port[2:0], cfg offset[9:0]}
    localparam int ADDR_W = 13;
    localparam int LD_ADDR_W = 12;
    localparam int NUM_PORTS = 6;
    localparam int NUM_REGS = 7;

    // Configuration space offsets per port
    localparam logic [9:0] OFS_CTRL = 10'h08C;
    localparam logic [9:0] OFS_L1PM = 10'h098;
    localparam logic [9:0] OFS_PMCAP = 10'h09C;
    localparam logic [9:0] OFS_VCTS = 10'h15C;
    localparam logic [9:0] OFS_VCMAP = 10'h160;
    localparam logic [9:0] OFS_L1SUB = 10'h244;
    localparam logic [9:0] OFS_LTSSM = 10'h33C;
    // Loader's own registers in port slot 7
    localparam logic [2:0] OWN_PORT = 3'h7;
    localparam logic [9:0] OFS_CMD = 10'h000;
    localparam logic [9:0] OFS_STAT = 10'h004;
    localparam int CMD_RELOAD_BIT = 0;
    localparam int STAT_DONE_BIT = 0;
    localparam int STAT_BUSY_BIT = 1;
    localparam int STAT_STEP_LSB = 4;

    // Storage slot of each configuration register
    localparam logic [2:0] IDX_CTRL = 3'h0;
    localparam logic [2:0] IDX_PMCAP = 3'h1;
    localparam logic [2:0] IDX_L1PM = 3'h2;
    localparam logic [2:0] IDX_VCTS = 3'h3;
    localparam logic [2:0] IDX_VCMAP = 3'h4;
    localparam logic [2:0] IDX_L1SUB = 3'h5;
    localparam logic [2:0] IDX_LTSSM = 3'h6;
    localparam logic [2:0] IDX_NONE = 3'h7;
    localparam logic [31:0] CFG_RESET_VAL = 32'h0000_0000;

    // Load address walk
    localparam logic [LD_ADDR_W-1:0] LD_CTRL_BASE = 12'h0F6;
    localparam logic [LD_ADDR_W-1:0] LD_VC_BASE = 12'h100;
    localparam logic [LD_ADDR_W-1:0] LD_PM_P0 = 12'h110;
    localparam logic [LD_ADDR_W-1:0] LD_STRIDE = 12'h002;
    localparam logic [3:0] CTRL_FIRST_PORT = 4'h3;
    localparam logic [3:0] STEP_VC0 = 4'h3;
    localparam logic [3:0] STEP_PM = 4'h9;
    localparam logic [3:0] STEP_LAST = 4'h9;

    // Control word fields
    localparam int CW_BYTE_LSB = 0;
    localparam int CW_DIS_BIT = 12;
    localparam int CW_PMCAP_BIT = 13;
    localparam int CW_RSTSEL_BIT = 14;
    localparam int CTRL_BYTE_LSB = 16;
    localparam int CTRL_DIS_BIT = 10;
    localparam int CTRL_RSTSEL_BIT = 11;
    localparam int PMCAP_BIT = 0;
    // Virtual channel word fields
    localparam int VW_TS_LSB = 0;
    localparam int VW_MAP_LSB = 8;
    localparam int VCTS_LSB = 16;
    localparam int VCMAP_LSB = 0;
    // Power management word fields
    localparam int PW_OPT_LSB = 0;
    localparam int PW_PM11_BIT = 4;
    localparam int PW_AS11_BIT = 5;
    localparam int PW_SUBST_BIT = 6;
    localparam int PW_LTSSM_LSB = 8;
    localparam int L1PM_OPT_LSB = 24;
    localparam int L1SUB_PM11_BIT = 1;
    localparam int L1SUB_AS11_BIT = 3;
    localparam int L1SUB_SUBST_BIT = 4;
    localparam int LTSSM_LSB = 0;

    typedef enum logic [0:0] {ST_LOAD, ST_READY} pcwl_state_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } pcwl_reg_req_t;

    typedef struct packed {
        logic ack;
        logic [15:0] word;
    } pcwl_load_rsp_t;
endpackage
`default_nettype wire

// >>> src/pcwl_loader.sv
// Port configuration word loader with per-port configuration registers
//
// Local design decisions: the placing of the registers and the address-and-strobe port.
`default_nettype none
// Operation
// [R01] Ports 3 to 5 take control word bits 7:0 into bits 23:16 of the 8Ch register.
// [R02] Control word bit 12 becomes port disable, bit 10 of the 8Ch register.
// [R03] Control word bit 13 becomes the power-management capability, bit 0 at 9Ch.
// [R04] Control word bit 14 becomes the reset selection, bit 11 at 8Ch.
// [R05] Each port's channel word bits 6:0 become the VC1 time slot, bits 22:16 at 15Ch.
// [R06] Channel word bits 15:8 become the traffic class map into VC1, bits 7:0 at 160h.
// [R07] Channel words for ports 0 to 5 sit at consecutive even load addresses from 100h.
// [R08] Port 0 power word bits 3:0 become the l1_power_options, bits 27:24 at 98h.
// [R09] Power word bits 4, 5 and 6 become bits 1, 3 and 4 at 244h.
// [R10] Port 0 power word bits 15:8 become the link training control byte at 33Ch.
// [R11] All words load after reset before register access, other bits keep defaults.
module pcwl_loader (
    input wire logic REF_CLK,
    input wire logic RST,
    input wire pcwl_pkg::pcwl_reg_req_t REG_REQ,
    output logic [31:0] RD_DATA,
    output logic LOAD_REQ,
    output logic [pcwl_pkg::LD_ADDR_W-1:0] LOAD_ADDR,
    input wire pcwl_pkg::pcwl_load_rsp_t LOAD_RSP,
    output logic LOAD_DONE
);
    typedef struct packed {
        pcwl_pkg::pcwl_state_t state;
        logic [3:0] step;
        logic req;
        logic [pcwl_pkg::LD_ADDR_W-1:0] addr;
        logic done;
        logic [31:0] rd_data;
        logic [pcwl_pkg::NUM_PORTS-1:0][pcwl_pkg::NUM_REGS-1:0][31:0] cfg;
    } pcwl_regs_t;

    pcwl_regs_t s_q;
    pcwl_regs_t s_d;

    // Offset to storage slot, shared by reads and writes
    function automatic logic [2:0] slot_of(input logic [9:0] ofs);
        logic [2:0] idx;
        idx = pcwl_pkg::IDX_NONE;
        if (ofs == pcwl_pkg::OFS_CTRL) begin
            idx = pcwl_pkg::IDX_CTRL;
        end else if (ofs == pcwl_pkg::OFS_PMCAP) begin
            idx = pcwl_pkg::IDX_PMCAP;
        end else if (ofs == pcwl_pkg::OFS_L1PM) begin
            idx = pcwl_pkg::IDX_L1PM;
        end else if (ofs == pcwl_pkg::OFS_VCTS) begin
            idx = pcwl_pkg::IDX_VCTS;
        end else if (ofs == pcwl_pkg::OFS_VCMAP) begin
            idx = pcwl_pkg::IDX_VCMAP;
        end else if (ofs == pcwl_pkg::OFS_L1SUB) begin
            idx = pcwl_pkg::IDX_L1SUB;
        end else if (ofs == pcwl_pkg::OFS_LTSSM) begin
            idx = pcwl_pkg::IDX_LTSSM;
        end
        return idx;
    endfunction

    // Load address of a walk step
    function automatic logic [pcwl_pkg::LD_ADDR_W-1:0] addr_of(input logic [3:0] step);
        logic [pcwl_pkg::LD_ADDR_W-1:0] a;
        a = pcwl_pkg::LD_PM_P0;
        if (step < pcwl_pkg::STEP_VC0) begin
            a = pcwl_pkg::LD_CTRL_BASE + pcwl_pkg::LD_STRIDE * {8'h00, step};
        end else if (step < pcwl_pkg::STEP_PM) begin
            a = pcwl_pkg::LD_VC_BASE
                + pcwl_pkg::LD_STRIDE * {8'h00, step - pcwl_pkg::STEP_VC0}; // [R07]
        end
        return a;
    endfunction

    logic [2:0] bus_port;
    logic [9:0] bus_ofs;
    logic [2:0] bus_slot;
    logic capture;
    logic reload_hit;
    logic [15:0] w;
    logic [2:0] ctrl_port;
    logic [2:0] vc_port;

    // Bus address split and capture qualifier
    assign bus_port = REG_REQ.addr[pcwl_pkg::ADDR_W-1:10];
    assign bus_ofs = REG_REQ.addr[9:0];
    assign bus_slot = slot_of(bus_ofs);
    assign capture = (s_q.state == pcwl_pkg::ST_LOAD) && s_q.req && LOAD_RSP.ack;
    assign w = LOAD_RSP.word;
    // Reload strobe seen on the bus, used by the checks below
    assign reload_hit = REG_REQ.wr && bus_port == pcwl_pkg::OWN_PORT
        && bus_ofs == pcwl_pkg::OFS_CMD && REG_REQ.wdata[pcwl_pkg::CMD_RELOAD_BIT];
    assign ctrl_port = 3'(s_q.step + pcwl_pkg::CTRL_FIRST_PORT);
    assign vc_port = 3'(s_q.step - pcwl_pkg::STEP_VC0);

    // Next state: load walk, field scatter and register port
    always_comb begin
        s_d = s_q;
        s_d.rd_data = 32'h0000_0000;
        case (s_q.state)
            pcwl_pkg::ST_LOAD: begin
                if (capture) begin
                    if (s_q.step < pcwl_pkg::STEP_VC0) begin
                        s_d.cfg[ctrl_port][pcwl_pkg::IDX_CTRL][pcwl_pkg::CTRL_BYTE_LSB +: 8] =
                            w[pcwl_pkg::CW_BYTE_LSB +: 8]; // [R01]
                        s_d.cfg[ctrl_port][pcwl_pkg::IDX_CTRL][pcwl_pkg::CTRL_DIS_BIT] =
                            w[pcwl_pkg::CW_DIS_BIT]; // [R02]
                        s_d.cfg[ctrl_port][pcwl_pkg::IDX_PMCAP][pcwl_pkg::PMCAP_BIT] =
                            w[pcwl_pkg::CW_PMCAP_BIT]; // [R03]
                        s_d.cfg[ctrl_port][pcwl_pkg::IDX_CTRL][pcwl_pkg::CTRL_RSTSEL_BIT] =
                            w[pcwl_pkg::CW_RSTSEL_BIT]; // [R04]
                    end else if (s_q.step < pcwl_pkg::STEP_PM) begin
                        s_d.cfg[vc_port][pcwl_pkg::IDX_VCTS][pcwl_pkg::VCTS_LSB +: 7] =
                            w[pcwl_pkg::VW_TS_LSB +: 7]; // [R05]
                        s_d.cfg[vc_port][pcwl_pkg::IDX_VCMAP][pcwl_pkg::VCMAP_LSB +: 8] =
                            w[pcwl_pkg::VW_MAP_LSB +: 8]; // [R06]
                    end else begin
                        s_d.cfg[0][pcwl_pkg::IDX_L1PM][pcwl_pkg::L1PM_OPT_LSB +: 4] =
                            w[pcwl_pkg::PW_OPT_LSB +: 4]; // [R08]
                        s_d.cfg[0][pcwl_pkg::IDX_L1SUB][pcwl_pkg::L1SUB_PM11_BIT] =
                            w[pcwl_pkg::PW_PM11_BIT]; // [R09]
                        s_d.cfg[0][pcwl_pkg::IDX_L1SUB][pcwl_pkg::L1SUB_AS11_BIT] =
                            w[pcwl_pkg::PW_AS11_BIT]; // [R09]
                        s_d.cfg[0][pcwl_pkg::IDX_L1SUB][pcwl_pkg::L1SUB_SUBST_BIT] =
                            w[pcwl_pkg::PW_SUBST_BIT]; // [R09]
                        s_d.cfg[0][pcwl_pkg::IDX_LTSSM][pcwl_pkg::LTSSM_LSB +: 8] =
                            w[pcwl_pkg::PW_LTSSM_LSB +: 8]; // [R10]
                    end
                    // Last word opens the register port
                    if (s_q.step == pcwl_pkg::STEP_LAST) begin
                        s_d.state = pcwl_pkg::ST_READY; // [R11]
                        s_d.done = 1'b1;
                    end else begin
                        s_d.step = s_q.step + 4'h1;
                    end
                end
            end
            pcwl_pkg::ST_READY: begin
                // Software writes replace whole words once loading is over
                if (REG_REQ.wr && bus_port < 3'(pcwl_pkg::NUM_PORTS)
                        && bus_slot != pcwl_pkg::IDX_NONE) begin
                    s_d.cfg[bus_port][bus_slot] = REG_REQ.wdata; // [R11]
                end
            end
            default: begin
                s_d.state = pcwl_pkg::ST_LOAD;
            end
        endcase

        // Reload re-walks the words; bits outside loaded fields are untouched
        if (REG_REQ.wr && bus_port == pcwl_pkg::OWN_PORT && bus_ofs == pcwl_pkg::OFS_CMD
                && REG_REQ.wdata[pcwl_pkg::CMD_RELOAD_BIT]) begin
            s_d.state = pcwl_pkg::ST_LOAD;
            s_d.step = 4'h0;
            s_d.done = 1'b0;
        end

        // Read data, one cycle after the strobe; config reads are blocked while loading
        if (REG_REQ.rd) begin
            if (bus_port == pcwl_pkg::OWN_PORT) begin
                if (bus_ofs == pcwl_pkg::OFS_STAT) begin
                    s_d.rd_data[pcwl_pkg::STAT_DONE_BIT] = s_q.done;
                    s_d.rd_data[pcwl_pkg::STAT_BUSY_BIT] = (s_q.state == pcwl_pkg::ST_LOAD);
                    s_d.rd_data[pcwl_pkg::STAT_STEP_LSB +: 4] = s_q.step;
                end
            end else if (bus_port < 3'(pcwl_pkg::NUM_PORTS)
                    && bus_slot != pcwl_pkg::IDX_NONE
                    && s_q.state == pcwl_pkg::ST_READY) begin
                s_d.rd_data = s_q.cfg[bus_port][bus_slot]; // [R11]
            end
        end

        // Request follows the walk; registered so the pins are flop outputs
        s_d.req = (s_d.state == pcwl_pkg::ST_LOAD);
        s_d.addr = s_d.req ? addr_of(s_d.step) : '0; // [R07]
    end

    // State register
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            s_q.state <= pcwl_pkg::ST_LOAD;
            s_q.step <= 4'h0;
            s_q.req <= 1'b0;
            s_q.addr <= '0;
            s_q.done <= 1'b0;
            s_q.rd_data <= 32'h0000_0000;
            s_q.cfg <= {(pcwl_pkg::NUM_PORTS * pcwl_pkg::NUM_REGS){pcwl_pkg::CFG_RESET_VAL}};
        end else begin
            s_q <= s_d;
        end
    end

    assign RD_DATA = s_q.rd_data;
    assign LOAD_REQ = s_q.req;
    assign LOAD_ADDR = s_q.addr;
    assign LOAD_DONE = s_q.done;

    // Checks
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);

    sequence s_ctrl_cap;
        capture && s_q.step < pcwl_pkg::STEP_VC0;
    endsequence
    sequence s_vc_cap;
        capture && s_q.step >= pcwl_pkg::STEP_VC0 && s_q.step < pcwl_pkg::STEP_PM;
    endsequence
    sequence s_pm_cap;
        capture && s_q.step == pcwl_pkg::STEP_PM;
    endsequence

    a_ctrl_byte_copy: assert property (s_ctrl_cap |=> // [R01]
        s_q.cfg[$past(ctrl_port)][pcwl_pkg::IDX_CTRL][23:16] == $past(w[7:0]))
        else $error("Control byte not copied to bits 23:16");
    a_port_disable_bit: assert property (s_ctrl_cap |=> // [R02]
        s_q.cfg[$past(ctrl_port)][pcwl_pkg::IDX_CTRL][10] == $past(w[12]))
        else $error("Port disable bit wrong");
    a_pm_cap_bit: assert property (s_ctrl_cap |=> // [R03]
        s_q.cfg[$past(ctrl_port)][pcwl_pkg::IDX_PMCAP][0] == $past(w[13]))
        else $error("Power management capability bit wrong");
    a_reset_sel_bit: assert property (s_ctrl_cap |=> // [R04]
        s_q.cfg[$past(ctrl_port)][pcwl_pkg::IDX_CTRL][11] == $past(w[14]))
        else $error("Reset select bit wrong");
    a_vc_time_slot: assert property (s_vc_cap |=> // [R05]
        s_q.cfg[$past(vc_port)][pcwl_pkg::IDX_VCTS][22:16] == $past(w[6:0]))
        else $error("VC1 time slot field wrong");
    a_vc_tc_map: assert property (s_vc_cap |=> // [R06]
        s_q.cfg[$past(vc_port)][pcwl_pkg::IDX_VCMAP][7:0] == $past(w[15:8]))
        else $error("Traffic class map wrong");
    a_vc_load_addr: assert property ((LOAD_REQ && s_q.step >= pcwl_pkg::STEP_VC0 // [R07]
        && s_q.step < pcwl_pkg::STEP_PM) |->
        LOAD_ADDR == 12'h100 + 12'(2 * (s_q.step - 4'h3)))
        else $error("Channel word address wrong");
    a_l1_options: assert property (s_pm_cap |=> // [R08]
        s_q.cfg[0][pcwl_pkg::IDX_L1PM][27:24] == $past(w[3:0]))
        else $error("L1 option bits wrong");
    a_l1_substates: assert property (s_pm_cap |=> // [R09]
        s_q.cfg[0][pcwl_pkg::IDX_L1SUB][1] == $past(w[4])
        && s_q.cfg[0][pcwl_pkg::IDX_L1SUB][3] == $past(w[5])
        && s_q.cfg[0][pcwl_pkg::IDX_L1SUB][4] == $past(w[6]))
        else $error("L1 substate flags wrong");
    a_ltssm_byte: assert property (s_pm_cap |=> ##0 LOAD_DONE && !LOAD_REQ // [R10]
        && s_q.cfg[0][pcwl_pkg::IDX_LTSSM][7:0] == $past(w[15:8]))
        else $error("Link training byte wrong or load not finished");
    a_blocked_read: assert property ((REG_REQ.rd && !LOAD_DONE // [R11]
        && bus_port != pcwl_pkg::OWN_PORT) |=> RD_DATA == 32'h0000_0000)
        else $error("Config read answered before load finished");

    // Load link: the request stands until a word is taken
    sequence s_wait_word;
        LOAD_REQ && !capture && !reload_hit;
    endsequence

    // Read qualifier of a mapped configuration word after loading
    sequence s_cfg_read;
        REG_REQ.rd && LOAD_DONE && bus_port < 3'(pcwl_pkg::NUM_PORTS)
            && bus_slot != pcwl_pkg::IDX_NONE;
    endsequence

    // Address and request must not move while the source is slow
    a_req_addr_hold: assert property (s_wait_word |=> // [R07]
        LOAD_REQ && LOAD_ADDR == $past(LOAD_ADDR))
        else $error("Load request or address moved before a word was taken");

    // Walk start and walk end addresses
    a_first_ctrl_addr: assert property ((LOAD_REQ && s_q.step < 4'h3) |-> // [R07]
        LOAD_ADDR == 12'h0F6 + 12'(2 * s_q.step))
        else $error("Control word address wrong");
    a_pm_word_addr: assert property ((LOAD_REQ && s_q.step == 4'h9) |-> // [R07]
        LOAD_ADDR == 12'h110)
        else $error("Power word address wrong");

    // The step counter never runs past the last word
    a_step_bound: assert property (s_q.step <= 4'h9) // [R07]
        else $error("Walk step out of range");

    // An idle link shows a zero address
    a_idle_addr_zero: assert property (!LOAD_REQ |-> LOAD_ADDR == 12'h000) // [R07]
        else $error("Load address not zero while idle");

    // Done and request are never high together
    a_done_excl_req: assert property (LOAD_DONE |-> !LOAD_REQ) // [R11]
        else $error("Load done while still requesting");

    // Writes during the walk leave the stored words alone
    a_wr_refused: assert property ((REG_REQ.wr && s_q.state == pcwl_pkg::ST_LOAD // [R11]
        && !capture && !reload_hit) |=> s_q.cfg == $past(s_q.cfg))
        else $error("Config write accepted while loading");

    // Bits next to a loaded field keep what they held
    a_ctrl_rest_kept: assert property (s_ctrl_cap |=> // [R11]
        s_q.cfg[$past(ctrl_port)][pcwl_pkg::IDX_CTRL][31:24]
            == $past(s_q.cfg[ctrl_port][pcwl_pkg::IDX_CTRL][31:24])
        && s_q.cfg[$past(ctrl_port)][pcwl_pkg::IDX_CTRL][9:0]
            == $past(s_q.cfg[ctrl_port][pcwl_pkg::IDX_CTRL][9:0]))
        else $error("Unloaded control bits changed");

    // Read answer stands one cycle only, and carries the stored word
    a_rd_one_cycle: assert property (!REG_REQ.rd |=> RD_DATA == 32'h0000_0000) // [R11]
        else $error("Read data outside the answer cycle");
    a_cfg_read_value: assert property (s_cfg_read |=> // [R11]
        RD_DATA == $past(s_q.cfg[bus_port][bus_slot]))
        else $error("Config read returned the wrong word");
endmodule
`default_nettype wire

// >>> tb/pcwl_word_src.sv
// Model of the configuration word source seen by the loader
`default_nettype none
module pcwl_word_src (
    input wire logic clk,
    input wire logic rst,
    input wire logic load_req,
    input wire logic [pcwl_pkg::LD_ADDR_W-1:0] load_addr,
    input wire logic [3:0] dly,
    input wire logic [7:0] seed,
    output pcwl_pkg::pcwl_load_rsp_t load_rsp
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cnt_q;
    logic [15:0] last_q;
    logic ack;

    // Answer once the wait runs out; dly of zero gives one word per cycle
    assign ack = load_req && (cnt_q >= dly);

    // Word line is not held outside the ack cycle, so show the inverse
    always_comb begin
        load_rsp.ack = ack;
        load_rsp.word = ack ? {load_addr[7:0] ^ seed, ~load_addr[7:0] ^ seed} : ~last_q;
    end

    // Wait counter restarts after every taken word
    always_ff @(posedge clk) begin
        if (rst || !load_req || ack) begin
            cnt_q <= 4'h0;
        end else begin
            cnt_q <= cnt_q + 4'h1;
        end
        if (rst) begin
            last_q <= 16'h0000;
        end else if (ack) begin
            last_q <= load_rsp.word;
        end
    end
endmodule
`default_nettype wire

// >>> tb/tb_pcwl_loader.sv
// Testbench of the port configuration word loader
`default_nettype none
module tb_pcwl_loader;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    pcwl_pkg::pcwl_reg_req_t reg_req = '0;
    logic [31:0] rd_data;
    logic load_req;
    logic [pcwl_pkg::LD_ADDR_W-1:0] load_addr;
    pcwl_pkg::pcwl_load_rsp_t load_rsp;
    logic load_done;
    logic [3:0] dly = 4'h3;
    logic [7:0] seed = 8'h5A;
    int fail_count = 0;
    int tests_run = 0;
    int cyc = 0;
    logic [11:0] seen_q[$];

    always #25 ref_clk = ~ref_clk;

    pcwl_loader i_pcwl_loader (.REF_CLK(ref_clk), .RST(rst), .REG_REQ(reg_req),
        .RD_DATA(rd_data), .LOAD_REQ(load_req), .LOAD_ADDR(load_addr),
        .LOAD_RSP(load_rsp), .LOAD_DONE(load_done));
    pcwl_word_src i_pcwl_word_src (.clk(ref_clk), .rst(rst), .load_req(load_req),
        .load_addr(load_addr), .dly(dly), .seed(seed), .load_rsp(load_rsp));

    // Record every taken load address; guard against a hang
    always @(posedge ref_clk) begin
        if (load_req === 1'b1 && load_rsp.ack === 1'b1) seen_q.push_back(load_addr);
        cyc++;
        if (cyc == 3000) begin
            fail_count++;
            wrap_up();
        end
    end

    function automatic logic [15:0] wf(input logic [11:0] a, input logic [7:0] s);
        return {a[7:0] ^ s, ~a[7:0] ^ s};
    endfunction

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [12:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_req.wr <= 1'b1;
        reg_req.addr <= a;
        reg_req.wdata <= d;
        @(posedge ref_clk);
        reg_req.wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [2:0] p, input logic [9:0] o, input logic [31:0] exp);
        @(posedge ref_clk);
        reg_req.rd <= 1'b1;
        reg_req.addr <= {p, o};
        @(posedge ref_clk);
        reg_req.rd <= 1'b0;
        #1;
        chk($sformatf("read %h", {p, o}), rd_data, exp);
    endtask

    task automatic wait_done(input logic v);
        int n;
        n = 0;
        while (load_done !== v && n < 200) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        chk("load done", {31'h0, load_done}, {31'h0, v});
    endtask

    // Walk order of the load addresses and idle state after the walk
    task automatic chk_walk();
        logic [11:0] e[10];
        e = '{12'h0F6, 12'h0F8, 12'h0FA, 12'h100, 12'h102, 12'h104, 12'h106, 12'h108,
            12'h10A, 12'h110};
        chk("word count", seen_q.size(), 32'h0000_000A);
        foreach (e[i]) begin
            if (i < seen_q.size()) begin
                chk("load addr", {20'h0, seen_q[i]}, {20'h0, e[i]});
            end
        end
        chk("idle req", {31'h0, load_req}, 32'h0000_0000);
        chk("idle addr", {20'h0, load_addr}, 32'h0000_0000);
        seen_q.delete();
    endtask

    // Every loaded register of every port against the word formula
    task automatic chk_all(input logic [7:0] s);
        logic [15:0] c, v, m;
        for (int p = 0; p < 6; p++) begin
            c = (p > 2) ? wf(12'h0F6 + 12'(2 * (p - 3)), s) : 16'h0000;
            v = wf(12'h100 + 12'(2 * p), s);
            m = (p == 0) ? wf(12'h110, s) : 16'h0000;
            rd(3'(p), pcwl_pkg::OFS_CTRL,
                {8'h00, c[7:0], 4'h0, c[14], c[12], 10'h000});
            rd(3'(p), pcwl_pkg::OFS_PMCAP, {31'h0, c[13]});
            rd(3'(p), pcwl_pkg::OFS_VCTS, {9'h000, v[6:0], 16'h0000});
            rd(3'(p), pcwl_pkg::OFS_VCMAP, {24'h00_0000, v[15:8]});
            rd(3'(p), pcwl_pkg::OFS_L1PM, {4'h0, m[3:0], 24'h00_0000});
            rd(3'(p), pcwl_pkg::OFS_L1SUB, {27'h0, m[6], m[5], 1'b0, m[4], 1'b0});
            rd(3'(p), pcwl_pkg::OFS_LTSSM, {24'h00_0000, m[15:8]});
        end
    endtask

    task automatic wrap_up();
        $display("Checks made %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        // Slow source: access before the walk ends is refused
        wr({3'h1, pcwl_pkg::OFS_CTRL}, 32'hFFFF_FFFF);
        rd(3'h1, pcwl_pkg::OFS_CTRL, 32'h0000_0000);
        wait_done(1'b1);
        chk_walk();
        chk_all(8'h5A);
        $display("Test slow load finished");
        // Reload with a back-to-back source and new word contents
        dly <= 4'h0;
        seed <= 8'hC3;
        wr({pcwl_pkg::OWN_PORT, pcwl_pkg::OFS_CMD}, 32'h0000_0001);
        wait_done(1'b0);
        wait_done(1'b1);
        chk_walk();
        chk_all(8'hC3);
        $display("Test fast reload finished");
        // Unmapped port and unmapped offset read as zero
        rd(3'h6, pcwl_pkg::OFS_CTRL, 32'h0000_0000);
        rd(3'h0, 10'h090, 32'h0000_0000);
        // Status after the walk, then a software write read back
        rd(pcwl_pkg::OWN_PORT, pcwl_pkg::OFS_STAT, 32'h0000_0091);
        wr({3'h2, pcwl_pkg::OFS_VCMAP}, 32'hA5A5_5A5A);
        rd(3'h2, pcwl_pkg::OFS_VCMAP, 32'hA5A5_5A5A);
        $display("Test registers finished");
        wrap_up();
    end
endmodule
`default_nettype wire
